// [crs_pkg.sv]
// Purpose: Shared constants for the clock and reset status flag block
// Assumes: One 25 MHz bus clock, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package crs_pkg;
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_FLAGS = 8'h00; // clock_reset_flags
	localparam logic [7:0] OFS_CTRL  = 8'h04; // Interrupt enables
	localparam logic [7:0] OFS_DIV   = 8'h08; // pll_output_divider
	localparam logic [7:0] OFS_TICK  = 8'h0C; // Periodic tick interval

	// ------------------------------------------------------------------
	// Bit positions in clock_reset_flags and control
	// ------------------------------------------------------------------
	localparam int BIT_TICK  = 7; // periodic_tick_flag
	localparam int BIT_POR   = 6; // poweron_reset_flag
	localparam int BIT_LVR   = 5; // lowvolt_reset_flag
	localparam int BIT_LOCKC = 4; // pll_tolerance_change_flag
	localparam int BIT_LOCK  = 3; // Live lock status
	localparam int BIT_BADA  = 2; // bad_address_reset_flag
	localparam int BIT_OSCC  = 1; // osc_status_change_flag
	localparam int BIT_QUAL  = 0; // osc_qualified_status

	localparam logic [7:0] STICKY_MASK = 8'hF6; // Write-one-to-clear bits
	localparam logic [7:0] CATCH_MASK  = 8'h64; // Reset causes caught in reset
	localparam logic [7:0] CTRL_MASK   = 8'h92; // Implemented enables

	// ------------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------------
	localparam logic [7:0]  FLAGS_RST = 8'h00;
	localparam logic [7:0]  CTRL_RST  = 8'h00;
	localparam logic [7:0]  DIV_RST   = 8'h00;
	localparam logic [15:0] TICK_RST  = 16'h0400;

	// ------------------------------------------------------------------
	// Divider and filter counts
	// ------------------------------------------------------------------
	localparam logic [7:0]  DIV_UNLOCKED = 8'h04; // Divide by four while unlocked
	localparam logic [7:0]  QUAL_EDGES   = 8'h10; // Clean edges before qualified
	localparam logic [15:0] MAX_GAP      = 16'h0400; // VCO ticks without an edge

	// ------------------------------------------------------------------
	// AXI responses
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [crs_flag_cell.sv]
// Purpose: One sticky event flag, set by hardware, cleared by writing one
// Assumes: Set and clear are single-cycle strobes on sys_clk
// Notes:   Set beats clear so a coinciding event survives
`timescale 1ns/1ps
module crs_flag_cell #(
	parameter logic RST_VAL  = 1'b0, // Value after reset
	parameter logic CATCH_RST = 1'b0 // Record the set input during reset
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic ce,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_q
);
	// ------------------------------------------------------------------
	// Flag storage
	// ------------------------------------------------------------------
	// Reset-cause flags must survive the reset they report
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flag_q <= RST_VAL | (CATCH_RST & set);
		end else if (ce) begin
			flag_q <= set | (flag_q & ~clr);
		end
	end
endmodule // crs_flag_cell

// [crs_osc_qualifier.sv]
// Purpose: Adaptive spike filter qualifying the external oscillator
// Assumes: Oscillator level and VCO ticks are synchronous samples
// Notes:   A gap under half the previous gap counts as a spike
`timescale 1ns/1ps
module crs_osc_qualifier #(
	parameter int GAP_W = 16 // Width of the edge gap counter
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic ce,
	input  wire logic osc_level,
	input  wire logic vco_tick,
	input  wire logic clear,
	output logic      qualified_q
);
	logic             osc_prev_q;  // Previous oscillator sample
	logic [GAP_W-1:0] gap_q;       // VCO ticks since last edge
	logic [GAP_W-1:0] last_gap_q;  // Gap before the latest edge
	logic [7:0]       good_q;      // Clean edges in a row
	logic             edge_seen;   // Oscillator toggled
	logic             spike;       // Edge arrived too early
	logic             stalled;     // No edge for too long

	assign edge_seen = osc_level ^ osc_prev_q;
	assign spike     = edge_seen & (gap_q < (last_gap_q >> 1));
	assign stalled   = (gap_q >= crs_pkg::MAX_GAP[GAP_W-1:0]);

	// ------------------------------------------------------------------
	// Gap measurement against the VCO reference
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			osc_prev_q <= 1'b0;
			gap_q      <= '0;
			last_gap_q <= '0;
		end else if (ce) begin
			osc_prev_q <= osc_level;
			if (edge_seen) begin
				gap_q      <= '0;
				last_gap_q <= gap_q;
			end else if (vco_tick && !stalled) begin
				gap_q <= gap_q + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Qualification state
	// ------------------------------------------------------------------
	// Any spike or stall restarts the count, so status only rises slowly
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			good_q      <= 8'h00;
			qualified_q <= 1'b0;
		end else if (ce) begin
			if (clear || spike || stalled) begin
				good_q      <= 8'h00;
				qualified_q <= 1'b0;
			end else if (edge_seen) begin
				if (good_q >= crs_pkg::QUAL_EDGES) begin
					qualified_q <= 1'b1;
				end else begin
					good_q <= good_q + 8'h01;
				end
			end
		end
	end
endmodule // crs_osc_qualifier

// [crs_clock_flags.sv]
// Purpose: Clock and reset status flags with AXI4-Lite register access
// Assumes: All pin inputs synchronous to sys_clk; VCO and osc are samples
// Notes:   Reset-cause inputs are held by the reset controller
// Notes on behaviour
// - Tick interval expiry sets bit seven
// - Flags clear only on written one
// - Tick flag with enable requests interrupt
// - Power-on reset sets bit six
// - Low-voltage reset sets bit five
// - Any lock change sets bit four
// - Lock-change flag with enable requests interrupt
// - Bit three reads live lock, read-only
// - Unlocked: output clock is VCO over four
// - Locked: VCO over divider plus one
// - Illegal-address reset sets bit two
// - Oscillator status change sets bit one
// - Osc-change flag with enable requests interrupt
// - Bit zero reads oscillator qualified, read-only
// - Unqualified oscillator gates CAN clock off
// - Full stop entry clears qualified status
// - Spike filter against VCO qualifies oscillator
// - Lock loss drops qualified, except pseudo stop
// - PLL always runs; software programs it validly
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module crs_clock_flags #(
	parameter int ADDR_W = 8, // AXI address width
	parameter int DIV_W  = 6  // pll_output_divider width
) (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              poweron_reset_evt,
	input  wire logic              lowvolt_reset_evt,
	input  wire logic              bad_address_reset_evt,
	input  wire logic              pll_lock_raw,
	input  wire logic              pseudo_stop_mode,
	input  wire logic              full_stop_entry,
	input  wire logic              external_osc_clock,
	input  wire logic              pll_vco_clock,
	output logic                   irq_tick,
	output logic                   irq_lock,
	output logic                   irq_osc,
	output logic [DIV_W:0]         pll_div_q,
	output logic                   pll_clk_en_q,
	output logic                   can_osc_clock_q,
	output logic                   osc_qualified_status,
	output logic                   pll_lock_status
);
	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [ADDR_W-1:0] aw_addr_q;   // Held write address
	logic              aw_held_q;   // Write address taken
	logic [31:0]       w_data_q;    // Held write data
	logic [3:0]        w_strb_q;    // Held byte strobes
	logic              w_held_q;    // Write data taken
	logic              bvalid_q;    // Write response pending
	logic [1:0]        bresp_q;     // Write response code
	logic              rvalid_q;    // Read data pending
	logic [31:0]       rdata_q;     // Read data register
	logic [1:0]        rresp_q;     // Read response code
	logic [7:0]        ctrl_q;      // Interrupt enables
	logic [DIV_W-1:0]  div_set_q;   // pll_output_divider
	logic [15:0]       tick_per_q;  // Tick interval in sys_clk cycles
	logic [15:0]       tick_cnt_q;  // Tick interval counter
	logic              lock_q;      // Registered lock sample
	logic              lock_prev_q; // Lock one cycle earlier
	logic              qual_prev_q; // Qualified one cycle earlier
	logic              vco_prev_q;  // Previous VCO sample
	logic [DIV_W:0]    div_cnt_q;   // Output divider counter
	logic [7:0]        flags_q;     // Sticky flags, live bits zero
	logic [7:0]        set_vec;     // Hardware set strobes
	logic [7:0]        clr_vec;     // Software clear strobes
	logic              osc_qual;    // Spike filter result
	logic              qual_clear;  // Force unqualified
	logic              wr_go;       // Write performed this cycle
	logic              rd_go;       // Read taken this cycle
	logic              wr_flags;    // Write to flags register
	logic              wr_ctrl;     // Write to control register
	logic              wr_div;      // Write to divider register
	logic              wr_tick;     // Write to tick register
	logic              wr_hit;      // Write address mapped
	logic              rd_hit;      // Read address mapped
	logic              tick_evt;    // Tick interval expired
	logic              vco_tick;    // VCO rising edge
	logic [7:0]        flags_rd;    // Flags as software sees them
	logic [31:0]       rd_mux;      // Selected read word
	logic [DIV_W:0]    div_d;       // Next output divisor

	// ------------------------------------------------------------------
	// AXI4-Lite decode
	// ------------------------------------------------------------------
	// Readies fall with ce so no handshake lands while state is frozen
	assign s_axi_awready = ce & ~aw_held_q & ~bvalid_q;
	assign s_axi_wready  = ce & ~w_held_q & ~bvalid_q;
	assign s_axi_arready = ce & ~rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	assign wr_go    = ce & aw_held_q & w_held_q & ~bvalid_q;
	assign rd_go    = s_axi_arvalid & s_axi_arready;
	assign wr_flags = wr_go & (aw_addr_q == crs_pkg::OFS_FLAGS);
	assign wr_ctrl  = wr_go & (aw_addr_q == crs_pkg::OFS_CTRL);
	assign wr_div   = wr_go & (aw_addr_q == crs_pkg::OFS_DIV);
	assign wr_tick  = wr_go & (aw_addr_q == crs_pkg::OFS_TICK);
	assign wr_hit   = wr_flags | wr_ctrl | wr_div | wr_tick;
	assign rd_hit   = (s_axi_araddr == crs_pkg::OFS_FLAGS) | (s_axi_araddr == crs_pkg::OFS_CTRL)
		| (s_axi_araddr == crs_pkg::OFS_DIV) | (s_axi_araddr == crs_pkg::OFS_TICK);

	// Live bits come straight from state, so writes to them do nothing
	assign flags_rd = (flags_q & crs_pkg::STICKY_MASK)
		| {4'h0, lock_q, 2'b00, osc_qual};

	assign rd_mux = (s_axi_araddr == crs_pkg::OFS_FLAGS) ? {24'h00_0000, flags_rd} :
		(s_axi_araddr == crs_pkg::OFS_CTRL) ? {24'h00_0000, ctrl_q} :
		(s_axi_araddr == crs_pkg::OFS_DIV) ? {{(32-DIV_W){1'b0}}, div_set_q} :
		(s_axi_araddr == crs_pkg::OFS_TICK) ? {16'h0000, tick_per_q} : 32'h0000_0000;

	// ------------------------------------------------------------------
	// AXI write channel capture and response
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= crs_pkg::RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? crs_pkg::RESP_OKAY : crs_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// AXI read channel
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= crs_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_mux;
				rresp_q  <= rd_hit ? crs_pkg::RESP_OKAY : crs_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Software settings
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_q     <= crs_pkg::CTRL_RST;
			div_set_q  <= crs_pkg::DIV_RST[DIV_W-1:0];
			tick_per_q <= crs_pkg::TICK_RST;
		end else if (ce) begin
			if (wr_ctrl && w_strb_q[0]) begin
				ctrl_q <= w_data_q[7:0] & crs_pkg::CTRL_MASK;
			end
			if (wr_div && w_strb_q[0]) begin
				div_set_q <= w_data_q[DIV_W-1:0];
			end
			if (wr_tick && w_strb_q[0]) begin
				tick_per_q[7:0] <= w_data_q[7:0];
			end
			if (wr_tick && w_strb_q[1]) begin
				tick_per_q[15:8] <= w_data_q[15:8];
			end
		end
	end

	// ------------------------------------------------------------------
	// Periodic tick and input sampling
	// ------------------------------------------------------------------
	assign tick_evt = ce & (tick_cnt_q >= tick_per_q);
	assign vco_tick = pll_vco_clock & ~vco_prev_q;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tick_cnt_q  <= 16'h0000;
			lock_q      <= 1'b0;
			lock_prev_q <= 1'b0;
			qual_prev_q <= 1'b0;
			vco_prev_q  <= 1'b0;
		end else if (ce) begin
			tick_cnt_q  <= tick_evt ? 16'h0000 : tick_cnt_q + 16'h0001;
			lock_q      <= pll_lock_raw;
			lock_prev_q <= lock_q;
			qual_prev_q <= osc_qual;
			vco_prev_q  <= pll_vco_clock;
		end
	end

	// ------------------------------------------------------------------
	// Sticky flags
	// ------------------------------------------------------------------
	assign set_vec = {tick_evt,
		poweron_reset_evt,
		lowvolt_reset_evt,
		lock_q ^ lock_prev_q,
		1'b0,
		bad_address_reset_evt,
		osc_qual ^ qual_prev_q,
		1'b0};
	assign clr_vec = (wr_flags && w_strb_q[0]) ? (w_data_q[7:0] & crs_pkg::STICKY_MASK) : 8'h00;

	for (genvar i = 0; i < 8; i++) begin : g_flag
		if (crs_pkg::STICKY_MASK[i]) begin : g_cell
			crs_flag_cell #(
				.RST_VAL   (crs_pkg::FLAGS_RST[i]),
				.CATCH_RST (crs_pkg::CATCH_MASK[i])
			) u_cell (
				.sys_clk (sys_clk),
				.reset   (reset),
				.ce      (ce),
				.set     (set_vec[i]),
				.clr     (clr_vec[i]),
				.flag_q  (flags_q[i])
			);
		end else begin : g_none
			assign flags_q[i] = 1'b0;
		end
	end

	assign irq_tick = flags_q[crs_pkg::BIT_TICK] & ctrl_q[crs_pkg::BIT_TICK];
	assign irq_lock = flags_q[crs_pkg::BIT_LOCKC] & ctrl_q[crs_pkg::BIT_LOCKC];
	assign irq_osc  = flags_q[crs_pkg::BIT_OSCC] & ctrl_q[crs_pkg::BIT_OSCC];

	// ------------------------------------------------------------------
	// Oscillator qualification
	// ------------------------------------------------------------------
	// Pseudo stop drops lock on purpose, so status is kept there
	assign qual_clear = full_stop_entry
		| (lock_prev_q & ~lock_q & ~pseudo_stop_mode);

	crs_osc_qualifier #(
		.GAP_W (16)
	) u_qual (
		.sys_clk     (sys_clk),
		.reset       (reset),
		.ce          (ce),
		.osc_level   (external_osc_clock),
		.vco_tick    (vco_tick),
		.clear       (qual_clear),
		.qualified_q (osc_qual)
	);

	assign osc_qualified_status = osc_qual;
	assign pll_lock_status      = lock_q;

	// ------------------------------------------------------------------
	// PLL output divider and CAN oscillator gate
	// ------------------------------------------------------------------
	// Divide by four until locked keeps the core below its limit
	assign div_d = lock_q ? ({1'b0, div_set_q} + 1'b1)
		: crs_pkg::DIV_UNLOCKED[DIV_W:0];

	// The divider runs whenever ce is high; it has no enable of its own
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pll_div_q       <= crs_pkg::DIV_UNLOCKED[DIV_W:0];
			div_cnt_q       <= '0;
			pll_clk_en_q    <= 1'b0;
			can_osc_clock_q <= 1'b0;
		end else if (ce) begin
			pll_div_q       <= div_d;
			pll_clk_en_q    <= vco_tick && (div_cnt_q + 1'b1 >= pll_div_q);
			can_osc_clock_q <= external_osc_clock & osc_qual;
			if (vco_tick) begin
				div_cnt_q <= (div_cnt_q + 1'b1 >= pll_div_q) ? '0 : div_cnt_q + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_tick_sets_flag: assert property (@(posedge sys_clk) disable iff (reset)
		tick_evt |=> flags_q[crs_pkg::BIT_TICK])
		else $error("tick expiry did not set flag");
	a_clear_needs_one: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(flags_q[crs_pkg::BIT_TICK]) |-> $past(clr_vec[crs_pkg::BIT_TICK]))
		else $error("tick flag cleared without written one");
	a_tick_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
		(tick_evt && ctrl_q[crs_pkg::BIT_TICK] && !wr_ctrl) |=> irq_tick)
		else $error("tick interrupt not raised");
	a_por_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && poweron_reset_evt) |=> flags_q[crs_pkg::BIT_POR])
		else $error("power-on flag not set");
	a_lvr_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && lowvolt_reset_evt) |=> flags_q[crs_pkg::BIT_LVR])
		else $error("low-voltage flag not set");
	a_lock_change_flag: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && $changed(lock_q)) |-> ##1 flags_q[crs_pkg::BIT_LOCKC])
		else $error("lock change flag not set");
	a_lock_readback: assert property (@(posedge sys_clk) disable iff (reset)
		(rd_go && s_axi_araddr == crs_pkg::OFS_FLAGS) |=> rdata_q[3] == $past(lock_q))
		else $error("lock readback wrong");
	a_div_unlocked: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && !lock_q) |=> pll_div_q == crs_pkg::DIV_UNLOCKED[DIV_W:0])
		else $error("unlocked divisor not four");
	a_div_locked: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && lock_q) |=> pll_div_q == {1'b0, $past(div_set_q)} + 1'b1)
		else $error("locked divisor wrong");
	a_osc_change_flag: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && $rose(osc_qual)) |-> ##1 flags_q[crs_pkg::BIT_OSCC])
		else $error("osc change flag not set");
	a_can_gate_off: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && !osc_qual) |=> !can_osc_clock_q)
		else $error("CAN clock passed while unqualified");
	a_fullstop_clear: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && full_stop_entry) |=> !osc_qual)
		else $error("full stop did not clear qualified");
	a_lost_lock_clear: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && lock_prev_q && !lock_q && !pseudo_stop_mode) |=> !osc_qual)
		else $error("lock loss kept qualified");
	a_set_beats_clear: assert property (@(posedge sys_clk) disable iff (reset)
		(ce && set_vec[crs_pkg::BIT_BADA] && clr_vec[crs_pkg::BIT_BADA])
		|=> flags_q[crs_pkg::BIT_BADA])
		else $error("clear beat set");
endmodule // crs_clock_flags

// [crs_clock_flags_tb.sv]
// Purpose: Self-checking bench for the clock and reset status flags
// Assumes: AXI4-Lite master on a 25 MHz sys_clk, synchronous reset
// Notes:   Tick interval is written small so the run stays short
`timescale 1ns/1ps
module crs_clock_flags_tb;
	// ---------------------------------------------------------------
	// Stimulus and observed signals
	// ---------------------------------------------------------------
	logic        sys_clk = 1'b0, reset = 1'b1, ce = 1'b1;
	logic        awv = 1'b0, wv = 1'b0, bry = 1'b1, arv = 1'b0, rry = 1'b1;
	logic        ps = 1'b0, ocp = 1'b0; // Pseudo stop, oscillator one cycle late
	logic [7:0]  awa = 8'h00, ara = 8'h00, oc = 8'h00; // oc paces the oscillator
	logic [31:0] wd = 32'h0000_0000, rdat, d;
	logic        por = 1'b1, lvr = 1'b0, bad = 1'b0, lk = 1'b0, fs = 1'b0, vco = 1'b0;
	logic        awy, wy, bv, ary, rv, itk, ilk, ios, den, can, qual, lks;
	logic [1:0]  br, rr, r;
	logic [6:0]  div;
	int          err_count = 0, tests_run = 0;

	crs_clock_flags dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wy), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ary),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.poweron_reset_evt(por), .lowvolt_reset_evt(lvr), .bad_address_reset_evt(bad),
		.pll_lock_raw(lk), .pseudo_stop_mode(ps), .full_stop_entry(fs),
		.external_osc_clock(oc[2]), .pll_vco_clock(vco), .irq_tick(itk), .irq_lock(ilk),
		.irq_osc(ios), .pll_div_q(div), .pll_clk_en_q(den), .can_osc_clock_q(can),
		.osc_qualified_status(qual), .pll_lock_status(lks));

	// Clock, and a VCO four times as fast as the oscillator so edge gaps stay even
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		vco <= ~vco;
		oc  <= oc + 8'h01;
		ocp <= oc[2];
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Handshakes are judged at the negedge, where the comb readies have settled
	task automatic wrt(input logic [7:0] a, input logic [31:0] v);
		logic b, ta, tw;
		awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; b = 1'b0;
		while (!b) begin
			@(negedge sys_clk);
			b = bv; r = br; ta = awy; tw = wy;
			@(posedge sys_clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end
	endtask
	task automatic rdt(input logic [7:0] a);
		logic b, t;
		ara <= a; arv <= 1'b1; b = 1'b0;
		while (!b) begin
			@(negedge sys_clk);
			b = rv; d = rdat; r = rr; t = ary;
			@(posedge sys_clk);
			if (t) arv <= 1'b0;
		end
	endtask
	task automatic end_of_test;
		if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_and_clear;
		rdt(crs_pkg::OFS_FLAGS); chk(32'(d[6:5]), 32'h2);
		chk(32'(div), 32'h4);
		wrt(crs_pkg::OFS_FLAGS, 32'h0000_0000); rdt(crs_pkg::OFS_FLAGS); chk(32'(d[6]), 32'h1);
		wrt(crs_pkg::OFS_FLAGS, 32'h0000_0040); rdt(crs_pkg::OFS_FLAGS); chk(32'(d[6]), 32'h0);
		lvr <= 1'b1; bad <= 1'b1; step(1); lvr <= 1'b0; bad <= 1'b0;
		rdt(crs_pkg::OFS_FLAGS); chk(32'(d[5]), 32'h1); chk(32'(d[2]), 32'h1);
		// Event held across the clearing write, so set and clear meet
		bad <= 1'b1; wrt(crs_pkg::OFS_FLAGS, 32'h0000_0004); bad <= 1'b0;
		rdt(crs_pkg::OFS_FLAGS); chk(32'(d[2]), 32'h1);
		wrt(crs_pkg::OFS_FLAGS, 32'h0000_0024); rdt(crs_pkg::OFS_FLAGS);
		chk(32'(d[5:2]), 32'h0);
		// Events seen while frozen must leave no trace
		ce <= 1'b0; lvr <= 1'b1; step(2); ce <= 1'b1; lvr <= 1'b0;
		rdt(crs_pkg::OFS_FLAGS); chk(32'(d[5]), 32'h0);
		wrt(8'h10, 32'h0000_0001); chk(32'(r), 32'(crs_pkg::RESP_SLVERR));
		rdt(8'h10); chk(32'(r), 32'(crs_pkg::RESP_SLVERR)); chk(d, 32'h0000_0000);
	endtask
	task automatic t_lock;
		wrt(crs_pkg::OFS_CTRL, 32'h0000_0092); wrt(crs_pkg::OFS_DIV, 32'h0000_0005);
		wrt(crs_pkg::OFS_FLAGS, 32'h0000_0010); chk(32'(div), 32'h4);
		lk <= 1'b1; step(4); chk(32'(lks), 32'h1);
		rdt(crs_pkg::OFS_FLAGS); chk(32'(d[4:3]), 32'h3); chk(32'(ilk), 32'h1);
		chk(32'(div), 32'h6);
		wrt(crs_pkg::OFS_FLAGS, 32'h0000_0018); rdt(crs_pkg::OFS_FLAGS);
		chk(32'(d[4:3]), 32'h1); chk(32'(ilk), 32'h0);
		lk <= 1'b0; step(4); rdt(crs_pkg::OFS_FLAGS);
		chk(32'(d[4:3]), 32'h2); chk(32'(div), 32'h4); chk(32'(qual), 32'h0);
	endtask
	task automatic t_osc_tick;
		int n;
		lk <= 1'b1; step(300);
		chk(32'(qual), 32'h1); chk(32'(ios), 32'h1); chk(32'(can), 32'(ocp));
		rdt(crs_pkg::OFS_FLAGS); chk(32'(d[1:0]), 32'h3);
		// Locked divisor six at one VCO tick per two cycles: a pulse each 12
		n = 0;
		repeat (48) begin
			step(1);
			n += int'(den);
		end
		chk(32'(n), 32'h4);
		// Lock lost on the way into pseudo stop keeps the oscillator status
		ps <= 1'b1; lk <= 1'b0; step(4);
		chk(32'(qual), 32'h1); chk(32'(lks), 32'h0);
		ps <= 1'b0; fs <= 1'b1; step(1); fs <= 1'b0; step(3);
		chk(32'(qual), 32'h0); chk(32'(can), 32'h0);
		wrt(crs_pkg::OFS_TICK, 32'h0000_0008); step(20);
		rdt(crs_pkg::OFS_FLAGS); chk(32'(d[7]), 32'h1); chk(32'(itk), 32'h1);
		wrt(crs_pkg::OFS_CTRL, 32'h0000_0000); chk(32'(itk), 32'h0);
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		step(12);
		reset <= 1'b0; por <= 1'b0; lvr <= 1'b0;
		step(1);
		t_reset_and_clear;
		t_lock;
		t_osc_tick;
		end_of_test;
	end
	initial begin
		#200000;
		err_count++;
		end_of_test;
	end
endmodule // crs_clock_flags_tb
